// file: design/gpp_consts.vh
// named constants for the general-purpose port block
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

// register indices; byte address is four times the index
`define GPP_IDX_DIR        6'h00
`define GPP_IDX_DIR_SET    6'h01
`define GPP_IDX_DIR_CLR    6'h02
`define GPP_IDX_DIR_TGL    6'h03
`define GPP_IDX_OUT        6'h04
`define GPP_IDX_OUT_SET    6'h05
`define GPP_IDX_OUT_CLR    6'h06
`define GPP_IDX_OUT_TGL    6'h07
`define GPP_IDX_IN         6'h08
`define GPP_IDX_FLAGS      6'h09
`define GPP_IDX_PAD0       6'h10
`define GPP_IDX_PAD7       6'h17
// fast alias map of the four busiest registers
`define GPP_IDX_ALIAS_DIR  6'h20
`define GPP_IDX_ALIAS_OUT  6'h21
`define GPP_IDX_ALIAS_IN   6'h22
`define GPP_IDX_ALIAS_FLG  6'h23

// address bits used by the decoder
`define GPP_ADDR_HI        7
`define GPP_ADDR_LO        2
`define GPP_ADDR_TOP       11
`define GPP_ADDR_UPPER_Z   4'h0

// pad setup byte layout
`define GPP_PAD_FLIP_BIT   7
`define GPP_PAD_PULL_BIT   3
`define GPP_PAD_SENSE_HI   2
`define GPP_PAD_SENSE_LO   0

// sense configuration codes
`define GPP_SENSE_NO_IRQ   3'h0
`define GPP_SENSE_BOTH     3'h1
`define GPP_SENSE_RISE     3'h2
`define GPP_SENSE_FALL     3'h3
`define GPP_SENSE_OFF      3'h4
`define GPP_SENSE_LOW      3'h5

// reset values
`define GPP_RST_BYTE       8'h00
`define GPP_RST_SENSE      3'h0
`define GPP_RST_DEAD       2'h0

// pins with clockless rise/fall wake and no dead time between interrupts
`define GPP_ASYNC_PINS     8'h44

// no new interrupt for this many cycles on the same pin outside GPP_ASYNC_PINS
`define GPP_DEAD_CYCLES    2'h3

`endif

// file: design/gpp_port.v
// eight-pin general-purpose port with APB register access
`timescale 1ns/1ps
`include "gpp_consts.vh"

module gpp_port
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [7:0]  pad_in,
    output wire [7:0]  pad_out,
    output wire [7:0]  pad_oe_b,
    output wire [7:0]  pad_pull_up,
    output wire [7:0]  pad_in_buf_en,
    output wire [7:0]  pin_event,
    output wire        irq,
    output wire        wake
);

    reg  [7:0]  dir;
    reg  [7:0]  out;
    reg  [7:0]  flags;
    reg  [7:0]  flip;
    reg  [7:0]  pull;
    reg  [23:0] sense;
    reg  [7:0]  next_dir;
    reg  [7:0]  next_out;
    reg  [7:0]  next_flip;
    reg  [7:0]  next_pull;
    reg  [23:0] next_sense;
    reg  [31:0] next_rdata;
    reg  [5:0]  eff_idx;
    reg         mapped;
    wire [5:0]  idx;
    wire        upper_zero;
    wire        wr;
    wire [7:0]  wbyte;
    wire [7:0]  pin_val;
    wire [7:0]  hit;
    wire [7:0]  in_en;
    wire [7:0]  wake_pin;
    wire [7:0]  flag_clr;
    wire [2:0]  pad_n;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign idx        = paddr[`GPP_ADDR_HI:`GPP_ADDR_LO];
    assign upper_zero = (paddr[`GPP_ADDR_TOP:`GPP_ADDR_HI+1]
                        == `GPP_ADDR_UPPER_Z);
    assign wbyte      = pwdata[7:0];
    assign pad_n      = eff_idx[2:0];

    always @*
    begin
        eff_idx = idx;
        mapped  = upper_zero;
        case (idx)
            `GPP_IDX_ALIAS_DIR: eff_idx = `GPP_IDX_DIR;
            `GPP_IDX_ALIAS_OUT: eff_idx = `GPP_IDX_OUT;
            `GPP_IDX_ALIAS_IN:  eff_idx = `GPP_IDX_IN;
            `GPP_IDX_ALIAS_FLG: eff_idx = `GPP_IDX_FLAGS;
            default:
            begin
                if (idx > `GPP_IDX_FLAGS && idx < `GPP_IDX_PAD0)
                    mapped = 1'b0;
                if (idx > `GPP_IDX_PAD7)
                    mapped = 1'b0;
            end
        endcase
    end

    // zero wait states: read data is captured in the setup cycle
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wr      = psel & penable & pwrite & mapped;

    // ------------------------------------------------------------------
    // register write logic
    // ------------------------------------------------------------------
    always @*
    begin
        next_dir   = dir;
        next_out   = out;
        next_flip  = flip;
        next_pull  = pull;
        next_sense = sense;
        if (wr)
        begin
            case (eff_idx)
                `GPP_IDX_DIR:     next_dir = wbyte;
                `GPP_IDX_DIR_SET: next_dir = dir | wbyte;
                `GPP_IDX_DIR_CLR: next_dir = dir & ~wbyte;
                `GPP_IDX_DIR_TGL: next_dir = dir ^ wbyte;
                `GPP_IDX_OUT:     next_out = wbyte;
                `GPP_IDX_OUT_SET: next_out = out | wbyte;
                `GPP_IDX_OUT_CLR: next_out = out & ~wbyte;
                `GPP_IDX_OUT_TGL: next_out = out ^ wbyte;
                `GPP_IDX_IN:      next_out = out ^ wbyte;
                default:
                begin
                    if (eff_idx >= `GPP_IDX_PAD0)
                    begin
                        next_flip[pad_n] = wbyte[`GPP_PAD_FLIP_BIT];
                        next_pull[pad_n] = wbyte[`GPP_PAD_PULL_BIT];
                        next_sense[pad_n*3 +: 3] =
                            wbyte[`GPP_PAD_SENSE_HI:`GPP_PAD_SENSE_LO];
                    end
                end
            endcase
        end
    end

    assign flag_clr = (wr && eff_idx == `GPP_IDX_FLAGS) ? wbyte
                                                        : `GPP_RST_BYTE;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dir   <= `GPP_RST_BYTE;
            out   <= `GPP_RST_BYTE;
            flip  <= `GPP_RST_BYTE;
            pull  <= `GPP_RST_BYTE;
            sense <= {8{`GPP_RST_SENSE}};
            flags <= `GPP_RST_BYTE;
        end
        else
        begin
            dir   <= next_dir;
            out   <= next_out;
            flip  <= next_flip;
            pull  <= next_pull;
            sense <= next_sense;
            flags <= (flags & ~flag_clr) | hit;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (eff_idx)
            `GPP_IDX_DIR:   next_rdata[7:0] = dir;
            `GPP_IDX_OUT:   next_rdata[7:0] = out;
            `GPP_IDX_IN:    next_rdata[7:0] = pin_val;
            `GPP_IDX_FLAGS: next_rdata[7:0] = flags;
            default:
            begin
                if (eff_idx >= `GPP_IDX_PAD0)
                begin
                    next_rdata[`GPP_PAD_FLIP_BIT] = flip[pad_n];
                    next_rdata[`GPP_PAD_PULL_BIT] = pull[pad_n];
                    next_rdata[`GPP_PAD_SENSE_HI:`GPP_PAD_SENSE_LO] =
                        sense[pad_n*3 +: 3];
                end
            end
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite && mapped)
            prdata <= next_rdata;
    end

    // ------------------------------------------------------------------
    // per-pin sensing
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_pin
            reg        sync1;
            reg        sync2;
            reg        prev;
            reg  [1:0] dead;
            reg        cond;
            wire [2:0] sc;
            wire       rise;
            wire       fall;
            wire       is_async;
            wire       raw_val;
            wire [7:0] amask;

            assign sc       = sense[gi*3 +: 3];
            assign amask    = `GPP_ASYNC_PINS;
            assign is_async = amask[gi];
            assign in_en[gi] = (sc != `GPP_SENSE_OFF);

            always @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sync1 <= 1'b0;
                    sync2 <= 1'b0;
                end
                else if (in_en[gi])
                begin
                    sync1 <= pad_in[gi];
                    sync2 <= sync1;
                end
            end

            assign pin_val[gi] = sync2 ^ flip[gi];

            assign rise = pin_val[gi] & ~prev;
            assign fall = ~pin_val[gi] & prev;

            always @*
            begin
                case (sc)
                    `GPP_SENSE_BOTH: cond = rise | fall;
                    `GPP_SENSE_RISE: cond = rise;
                    `GPP_SENSE_FALL: cond = fall;
                    `GPP_SENSE_LOW:  cond = ~pin_val[gi];
                    default:         cond = 1'b0;
                endcase
            end

            assign hit[gi] = cond & (is_async | (dead == `GPP_RST_DEAD));

            always @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    prev <= 1'b0;
                    dead <= `GPP_RST_DEAD;
                end
                else
                begin
                    if (in_en[gi])
                        prev <= pin_val[gi];
                    if (hit[gi] && !is_async)
                        dead <= `GPP_DEAD_CYCLES;
                    else if (dead != `GPP_RST_DEAD)
                        dead <= dead - 2'h1;
                end
            end

            // clockless wake path: raw pad against the last synced
            // level, so it still works with the clock stopped
            assign raw_val = pad_in[gi] ^ flip[gi];

            assign wake_pin[gi] = in_en[gi] & (
                ((sc == `GPP_SENSE_BOTH) & (raw_val ^ prev)) |
                ((sc == `GPP_SENSE_LOW) & ~raw_val) |
                (is_async & (sc == `GPP_SENSE_RISE) & raw_val & ~prev) |
                (is_async & (sc == `GPP_SENSE_FALL) & ~raw_val & prev));

            assign pin_event[gi] = pin_val[gi] & in_en[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // pad and request outputs
    // ------------------------------------------------------------------
    // driven value flipped
    assign pad_out       = out ^ flip;
    assign pad_oe_b      = ~dir;
    assign pad_pull_up   = pull;
    assign pad_in_buf_en = in_en;
    assign irq           = |flags;
    assign wake          = |wake_pin;

endmodule

// file: tb/gpp_chk.sv
// port-level assertions for the general-purpose port
`timescale 1ns/1ps
`include "gpp_consts.vh"

module gpp_chk
(
    input wire        clk,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [7:0]  pad_out,
    input wire [7:0]  pad_oe_b,
    input wire [7:0]  pad_pull_up,
    input wire [7:0]  pad_in_buf_en,
    input wire [7:0]  pin_event,
    input wire        irq
);
    wire [5:0] ix = paddr[7:2];
    wire       wr = psel & penable & pwrite & (paddr[11:8] == 4'h0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    rst_pads_a: assert property (disable iff (1'b0)
        !rst_b |-> pad_oe_b == 8'hFF && pad_in_buf_en == 8'hFF)
        else $error("pads not tri-stated in reset");
    event_off_a: assert property (
        (pin_event & ~pad_in_buf_en) == 8'h00)
        else $error("event high on disabled input");
    dir_set_a: assert property (
        wr && ix == `GPP_IDX_DIR_SET |=>
        pad_oe_b == ($past(pad_oe_b) & ~$past(pwdata[7:0])))
        else $error("drive enable set wrong");
    dir_clr_a: assert property (
        wr && ix == `GPP_IDX_DIR_CLR |=>
        pad_oe_b == ($past(pad_oe_b) | $past(pwdata[7:0])))
        else $error("drive enable clear wrong");
    dir_tgl_a: assert property (
        wr && ix == `GPP_IDX_DIR_TGL |=>
        pad_oe_b == ($past(pad_oe_b) ^ $past(pwdata[7:0])))
        else $error("drive enable toggle wrong");
    out_tgl_a: assert property (
        wr && (ix == `GPP_IDX_OUT_TGL || ix == `GPP_IDX_IN) |=>
        pad_out == ($past(pad_out) ^ $past(pwdata[7:0])))
        else $error("drive value toggle wrong");
    alias_dir_a: assert property (
        wr && ix == `GPP_IDX_ALIAS_DIR |=> pad_oe_b == ~$past(pwdata[7:0]))
        else $error("alias drive enable write wrong");
    irq_hold_a: assert property (
        $fell(irq) |-> $past(wr) && ($past(ix) == `GPP_IDX_FLAGS ||
        $past(ix) == `GPP_IDX_ALIAS_FLG))
        else $error("irq dropped without flag clear");
    pull_set_a: assert property (
        wr && ix[5:3] == 3'h2 |=> pad_pull_up[$past(ix[2:0])] ==
        $past(pwdata[`GPP_PAD_PULL_BIT]))
        else $error("pull-up bit not taken");

    cover property (wr && ix == `GPP_IDX_FLAGS);
    cover property ($rose(irq));
    cover property (pad_in_buf_en != 8'hFF);
endmodule

// file: tb/gpp_pads.sv
// pad and board model on the pin side of the port
`timescale 1ns/1ps

module gpp_pads
(
    input  wire       clk,
    input  wire [7:0] pad_out,
    input  wire [7:0] pad_oe_b,
    input  wire [7:0] pad_pull_up,
    input  wire [7:0] ext,
    input  wire [7:0] ext_en,
    output wire [7:0] pad_in
);
    // an open pad with no bias wanders every cycle, never holds a value
    reg [7:0] flt = 8'h55;

    always @(posedge clk)
        flt <= ~flt;

    assign pad_in = (~pad_oe_b & pad_out) | (pad_oe_b & ((ext_en & ext) |
                    (~ext_en & (pad_pull_up | flt))));
endmodule

// file: tb/testbench.sv
// self-checking bench for the eight-pin port
`timescale 1ns/1ps
`include "gpp_consts.vh"

module testbench;
    reg         clk = 1'h0;
    reg         rst_b = 1'h0;
    reg         psel = 1'h0;
    reg         penable = 1'h0;
    reg         pwrite = 1'h0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [7:0]  ext = 8'h00;
    reg  [7:0]  ext_en = 8'hFF;
    reg  [7:0]  dir = 8'h00;
    reg  [7:0]  out = 8'h00;
    reg  [7:0]  wd;
    reg  [5:0]  ix;
    reg  [31:0] rq;
    reg         e;
    reg  [2:0]  sc;
    reg         er;
    reg         ef;
    wire [31:0] prdata;
    wire        pready, pslverr, irq, wake;
    wire [7:0]  pad_in, pad_out, pad_oe_b, pad_pull_up, pad_in_buf_en;
    wire [7:0]  pin_event;
    integer     n_mismatch = 0, compares = 0, seed = 66, cyc = 0, i;

    always #12.5 clk = ~clk;

    gpp_port dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_b(pad_oe_b), .pad_pull_up(pad_pull_up),
        .pad_in_buf_en(pad_in_buf_en), .pin_event(pin_event),
        .irq(irq), .wake(wake));
    gpp_pads pads_u (.clk(clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
        .pad_pull_up(pad_pull_up), .ext(ext), .ext_en(ext_en),
        .pad_in(pad_in));

    task end_of_test;
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error timeout");
            end_of_test;
        end
    end

    task chk(input string nm, input [7:0] ex, input [7:0] gt);
        compares = compares + 1;
        if (gt !== ex)
        begin
            n_mismatch = n_mismatch + 1;
            $display("Error %s expected %h seen %h", nm, ex, gt);
        end
    endtask

    // waits for pready however long the slave takes
    task apb(input [5:0] x, input w, input [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {4'h0, x, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rq = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask

    task rd(input [5:0] x, input string nm, input [7:0] ex);
        apb(x, 1'h0, 8'h00);
        chk(nm, ex, rq[7:0]);
    endtask

    function [15:0] nx(input [5:0] x, input [7:0] dv, ov, w);
    begin
        case (x)
            `GPP_IDX_DIR, `GPP_IDX_ALIAS_DIR: dv = w;
            `GPP_IDX_DIR_SET: dv = dv | w;
            `GPP_IDX_DIR_CLR: dv = dv & ~w;
            `GPP_IDX_DIR_TGL: dv = dv ^ w;
            `GPP_IDX_OUT, `GPP_IDX_ALIAS_OUT: ov = w;
            `GPP_IDX_OUT_SET: ov = ov | w;
            `GPP_IDX_OUT_CLR: ov = ov & ~w;
            default: ov = ov ^ w;
        endcase
        nx = {dv, ov};
    end
    endfunction

    // driven pins read back their own value, others the pad
    function [7:0] xin(input [7:0] v);
        xin = (dir & out) | (~dir & v);
    endfunction

    initial
    begin
        repeat (2) @(posedge clk);
        chk("oe_b", 8'hFF, pad_oe_b);
        chk("in_buf", 8'hFF, pad_in_buf_en);
        rst_b <= 1'h1;
        rd(`GPP_IDX_DIR, "dir", 8'h00);
        apb(6'h0A, 1'h0, 8'h00);
        chk("slverr", 8'h01, {7'h0, e});
        for (i = 0; i < 40; i = i + 1)
        begin
            @(posedge clk) ext <= $random(seed);
            ix = $unsigned($random(seed)) % 12;
            if (ix > 6'h08)
                ix = ix + 6'h17;
            wd = $random(seed);
            apb(ix, 1'h1, wd);
            {dir, out} = nx(ix, dir, out, wd);
            rd(`GPP_IDX_DIR, "dir", dir);
            rd(`GPP_IDX_OUT, "out", out);
            rd(`GPP_IDX_IN, "in", xin(ext));
            chk("oe_b", ~dir, pad_oe_b);
        end
        apb(`GPP_IDX_PAD0, 1'h1, 8'h80);
        chk("flip_out", out ^ 8'h01, pad_out);
        repeat (3) @(posedge clk);
        rd(`GPP_IDX_IN, "flip_in", xin(ext) ^ (~dir & 8'h01));
        apb(`GPP_IDX_PAD0, 1'h1, 8'h00);
        apb(`GPP_IDX_DIR_CLR, 1'h1, 8'h08);
        dir = dir & 8'hF7;
        @(posedge clk) ext_en <= 8'hF7;
        apb(`GPP_IDX_PAD0 + 6'h03, 1'h1, 8'h08);
        chk("pull", 8'h08, pad_pull_up);
        repeat (3) @(posedge clk);
        rd(`GPP_IDX_IN, "pull_in", xin(ext) | 8'h08);
        apb(`GPP_IDX_PAD0 + 6'h03, 1'h1, 8'h00);
        @(posedge clk) ext_en <= 8'hFF;
        apb(`GPP_IDX_PAD0 + 6'h04, 1'h1, {5'h0, `GPP_SENSE_OFF});
        chk("buf_en", 8'hEF, pad_in_buf_en);
        chk("event", 8'h00, pin_event & 8'h10);
        apb(`GPP_IDX_PAD0 + 6'h04, 1'h1, 8'h00);
        apb(`GPP_IDX_ALIAS_DIR, 1'h1, 8'h00);
        dir = 8'h00;
        for (i = 0; i < 5; i = i + 1)
        begin
            sc = (i == 4) ? `GPP_SENSE_LOW : i[2:0];
            er = sc == `GPP_SENSE_BOTH || sc == `GPP_SENSE_RISE || i == 4;
            ef = sc == `GPP_SENSE_BOTH || sc == `GPP_SENSE_FALL || i == 4;
            @(posedge clk) ext[1] <= 1'h0;
            apb(`GPP_IDX_PAD0 + 6'h01, 1'h1, {5'h0, sc});
            repeat (4) @(posedge clk);
            apb(`GPP_IDX_FLAGS, 1'h1, 8'hFF);
            @(posedge clk) ext[1] <= 1'h1;
            repeat (4) @(posedge clk);
            rd(`GPP_IDX_FLAGS, "rise", {6'h0, er, 1'h0});
            chk("irq", {7'h0, er}, {7'h0, irq});
            apb(`GPP_IDX_ALIAS_FLG, 1'h1, 8'hFF);
            @(posedge clk) ext[1] <= 1'h0;
            repeat (4) @(posedge clk);
            rd(`GPP_IDX_FLAGS, "fall", {6'h0, ef, 1'h0});
            chk("wake", {7'h0, i == 4}, {7'h0, wake});
        end
        apb(`GPP_IDX_PAD0 + 6'h01, 1'h1, 8'h00);
        apb(`GPP_IDX_FLAGS, 1'h1, 8'hFF);
        chk("irq_clr", 8'h00, {7'h0, irq});
        end_of_test;
    end
endmodule

bind gpp_port gpp_chk chk_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pad_out(pad_out), .pad_oe_b(pad_oe_b), .pad_pull_up(pad_pull_up),
    .pad_in_buf_en(pad_in_buf_en), .pin_event(pin_event), .irq(irq));
